/* bench/adv_timer_checker.sv */
// port-level assertions of the timer block
`timescale 1ns/1ns
module adv_timer_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        brakeIn,
   input wire logic [3:0]  chanOutEn,
   input wire logic [2:0]  compOutEn,
   input wire logic        updateEvent
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // setup of a read, then its access cycle
   sequence rdAcc(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a ##1 psel && penable;
   endsequence
   ready_always_a: assert property (pready)
      else $error("pready low");
   enpol_top_a: assert property (
      rdAcc(8'h20) |-> prdata[31:14] == 18'h0)
      else $error("enable word top bits set");
   repeat_top_a: assert property (
      rdAcc(8'h30) |-> prdata[31:8] == 24'h0)
      else $error("repeat word top bits set");
   value_high_a: assert property (
      psel && penable && paddr inside {8'h34, 8'h38, 8'h3C, 8'h40}
      |-> prdata[31:16] == 16'h0 && !pslverr)
      else $error("value word bad");
   count_high_a: assert property (
      psel && penable && paddr == 8'h24 |-> prdata[31:16] == 16'h0)
      else $error("count word bad");
   update_pulse_a: assert property (
      updateEvent |=> !updateEvent)
      else $error("update longer than one cycle");
   brake_off_a: assert property (
      $rose(brakeIn) ##1 brakeIn[*5] |-> chanOutEn == 4'hF
      && compOutEn == 3'h7)
      else $error("pins still driven in brake");
   // reset must leave pins released even while it is held
   reset_quiet_a: assert property (disable iff (1'h0)
      reset |=> chanOutEn == 4'hF && compOutEn == 3'h7 && !updateEvent)
      else $error("pins driven after reset");
endmodule
bind adv_timer adv_timer_checker adv_timer_checker_inst (.clk(clk),
   .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .brakeIn(brakeIn), .chanOutEn(chanOutEn), .compOutEn(compOutEn),
   .updateEvent(updateEvent));

/* bench/adv_timer_test.sv */
// self-checking bench of the timer block
`timescale 1ns/1ns
module adv_timer_test;
   logic        clk = 1'h0;
   logic        reset = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  chanIn;
   logic        brakeIn;
   logic [3:0]  chanOut;
   logic [3:0]  chanOutEn;
   logic [2:0]  compOut;
   logic [2:0]  compOutEn;
   logic        updateEvent;
   logic        e;
   logic [31:0] q;
   logic [31:0] v;
   int          n;
   int          error_cnt = 0;
   int          tests_run = 0;
   always #50 clk = ~clk;
   adv_timer adv_timer_inst (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chanIn(chanIn), .brakeIn(brakeIn), .chanOut(chanOut),
      .chanOutEn(chanOutEn), .compOut(compOut), .compOutEn(compOutEn),
      .updateEvent(updateEvent));
   timer_pins timer_pins_inst (.clk(clk), .chanOut(chanOut),
      .chanOutEn(chanOutEn), .chanIn(chanIn), .brakeIn(brakeIn));
   // ****************************************************
   // bus cycles and comparison
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk(q, x);
   endtask
   task automatic waitUpd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (updateEvent !== 1'h1 && n < 300);
      // a missing update counts as a mismatch
      chk(updateEvent, 32'h1);
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic regs;
      logic [7:0] adr [7] = '{8'h20, 8'h24, 8'h30, 8'h34, 8'h38,
                              8'h3C, 8'h40};
      foreach (adr[i]) rdc(adr[i], 32'h0);
      wr(8'h20, 32'hFFFFFFFF);
      rdc(8'h20, 32'h3FFF);
      wr(8'h30, 32'hFFFFFFFF);
      rdc(8'h30, 32'hFF);
      wr(8'h40, 32'hFFFF5AC3);
      rdc(8'h40, 32'h5AC3);
      rdc(8'h04, 32'h0);
      chk(e, 32'h1);
      wr(8'h20, 32'h0);
      wr(8'h30, 32'h0);
   endtask
   task automatic counting;
      wr(8'h24, 32'h5);
      repeat (8) @(posedge clk);
      rdc(8'h24, 32'h5);
      wr(8'h28, 32'h3);
      wr(8'h2C, 32'h64);
      rd(8'h24);
      v = q;
      rd(8'h24);
      chk(q - v, 32'h3);
      waitUpd;
      wr(8'h2C, 32'hFFFF);
      rd(8'h24);
      v = q;
      repeat (37) @(posedge clk);
      rd(8'h24);
      chk(q - v, 32'hA);
   endtask
   task automatic repeating;
      wr(8'h2C, 32'h3);
      wr(8'h24, 32'h0);
      wr(8'h30, 32'h2);
      waitUpd;
      waitUpd;
      chk(n, 32'h30);
   endtask
   task automatic outputs;
      wr(8'h34, 32'h0);
      wr(8'h44, 32'h8000);
      wr(8'h20, 32'h1);
      repeat (3) @(posedge clk);
      chk({chanOutEn[0], chanIn[0]}, 32'h0);
      wr(8'h20, 32'h3);
      repeat (3) @(posedge clk);
      chk({chanOutEn[0], chanIn[0]}, 32'h1);
      wr(8'h34, 32'hFFFF);
      repeat (3) @(posedge clk);
      chk({chanOutEn[0], chanIn[0]}, 32'h0);
      wr(8'h20, 32'hF);
      repeat (3) @(posedge clk);
      chk({compOutEn[0], compOut[0]}, 32'h1);
   endtask
   task automatic braking;
      timer_pins_inst.setBrake(1'h1);
      repeat (8) @(posedge clk);
      chk(chanOutEn, 32'hF);
      chk(compOutEn, 32'h7);
      rd(8'h44);
      chk(q[15], 32'h0);
      timer_pins_inst.setBrake(1'h0);
   endtask
   task automatic capture;
      wr(8'h18, 32'h4);
      wr(8'h38, 32'hABCD);
      timer_pins_inst.setLevel(1, 1'h1);
      repeat (6) @(posedge clk);
      rdc(8'h38, 32'hABCD);
      wr(8'h20, 32'h30);
      timer_pins_inst.setLevel(1, 1'h0);
      repeat (6) @(posedge clk);
      rd(8'h38);
      chk(q <= 32'h3, 32'h1);
      wr(8'h38, 32'hABCD);
      timer_pins_inst.setLevel(1, 1'h1);
      repeat (6) @(posedge clk);
      rdc(8'h38, 32'hABCD);
   endtask
   task automatic locking;
      // lock field takes one write per reset, so reset again first
      @(posedge clk);
      reset <= 1'h1;
      repeat (3) @(posedge clk);
      reset <= 1'h0;
      rdc(8'h24, 32'h0);
      rdc(8'h38, 32'h0);
      wr(8'h20, 32'h30);
      wr(8'h44, 32'h8200);
      rdc(8'h44, 32'h8200);
      wr(8'h20, 32'h1);
      rdc(8'h20, 32'h21);
      wr(8'h20, 32'h2);
      rdc(8'h20, 32'h20);
      wr(8'h44, 32'h8000);
      rdc(8'h44, 32'h8200);
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'h0;
      regs;
      counting;
      repeating;
      outputs;
      braking;
      capture;
      locking;
      summarize;
   end
   // far longer than the whole sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize;
   end
endmodule

/* bench/timer_pins.sv */
// pin-side model: capture sources, brake switch, pad resolution
`timescale 1ns/1ns
module timer_pins (
   input  wire logic       clk,
   input  wire logic [3:0] chanOut,
   input  wire logic [3:0] chanOutEn,
   output logic      [3:0] chanIn,
   output logic            brakeIn
);
   logic [3:0] extLevel = 4'h0;
   // pad follows the timer only where its enable is low
   assign chanIn = (chanOut & ~chanOutEn) | (extLevel & chanOutEn);
   initial brakeIn = 1'h0;
   task automatic setLevel(input int ch, input logic lvl);
      @(posedge clk);
      extLevel[ch] <= lvl;
   endtask
   task automatic setBrake(input logic lvl);
      @(posedge clk);
      brakeIn <= lvl;
   endtask
endmodule

/* hw/adv_timer.sv */
// advanced timer: enable/polarity, counter, prescaler, reload, repeat, compare
`timescale 1ns/1ns
`include "timer_defines.svh"
// Overview of operation
// - output polarity bit set makes output active low
// - input polarity set captures on falling edge
// - polarity writes ignored at lock level two or three
// - output enable routes compare output to pin
// - input enable gates counter capture into value register
// - four main pairs, three complementary pairs of bits
// - channel four polarity/enable only, top bits zero
// - counter reads live, writable, resets to zero
// - counter clock is input divided by prescaler plus one
// - reload value reloads counter; zero stops it
// - repeat count eight bits, upper byte zero
// - four sixteen-bit compare/capture registers reset zero
// - brake clears main output enable one cycle after its two-stage sync
// - direction field selects compare or capture meaning
module adv_timer (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  chanIn,
   input  wire logic        brakeIn,
   output logic      [3:0]  chanOut,
   output logic      [3:0]  chanOutEn,
   output logic      [2:0]  compOut,
   output logic      [2:0]  compOutEn,
   output logic             updateEvent
);
   // ****************************************
   // register state
   // ****************************************
   timer_pkg::word16_t enPol_r;
   timer_pkg::word16_t count_r;
   timer_pkg::word16_t divLoad_r;
   timer_pkg::word16_t divActive_r;
   timer_pkg::word16_t divCount_r;
   timer_pkg::word16_t reload_r;
   logic [7:0]         repeatLoad_r;
   logic [7:0]         repeatCount_r;
   timer_pkg::word16_t value_r [4];
   logic [7:0]         dirSel_r;
   timer_pkg::word16_t brake_r;
   logic               lockSet_r;
   logic [3:0]         inSync1_r;
   logic [3:0]         inSync2_r;
   logic [3:0]         inPrev_r;
   logic               brkSync1_r;
   logic               brkSync2_r;

   logic        wrEn;
   logic        divTick;
   logic        overflow;
   logic        update;
   logic [1:0]  lockLevel;
   logic        main_output_enable;
   logic [15:0] enPolMask;
   logic [31:0] readWord;
   logic [3:0]  capEdge;
   logic [3:0]  isOutput;
   logic [3:0]  cmpActive;
   logic [3:0]  mainEn;
   logic [3:0]  mainPol;
   logic [3:0]  idleLvl;

   // ****************************************
   // bus slave
   // ****************************************
   // zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wrEn    = psel & penable & pwrite;
   assign lockLevel = brake_r[`BRK_LOCK_LSB +: 2];
   assign main_output_enable     = brake_r[`BRK_MOE_BIT];

   always_comb begin
      if (lockLevel >= `LOCK_LEVEL2) begin
         enPolMask = `ENPOL_WMASK & `ENPOL_LOCK_WMASK;
      end else begin
         enPolMask = `ENPOL_WMASK;
      end
   end

   always_comb begin
      pslverr  = 1'b0;
      readWord = `ZERO32;
      case (paddr)
         `OFF_DIRECTION:  readWord = {24'h00_0000, dirSel_r};
         `OFF_CHAN_ENPOL: readWord = {16'h0000, enPol_r & `ENPOL_WMASK};
         `OFF_COUNT:      readWord = {16'h0000, count_r};
         `OFF_PRESCALE:   readWord = {16'h0000, divLoad_r};
         `OFF_RELOAD:     readWord = {16'h0000, reload_r};
         `OFF_REPEAT:     readWord = {24'h00_0000, repeatLoad_r};
         `OFF_CH1_VALUE:  readWord = {16'h0000, value_r[0]};
         `OFF_CH2_VALUE:  readWord = {16'h0000, value_r[1]};
         `OFF_CH3_VALUE:  readWord = {16'h0000, value_r[2]};
         `OFF_CH4_VALUE:  readWord = {16'h0000, value_r[3]};
         `OFF_BRAKE_CTRL: readWord = {16'h0000, brake_r};
         default:         pslverr = psel & penable;
      endcase
   end

   // read word is taken in the setup cycle so prdata leaves a flop;
   // a live count therefore reads as it stood one cycle earlier
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= `ZERO32;
      end else if (psel && !penable && !pwrite) begin
         prdata <= readWord;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         enPol_r <= `ZERO16;
      end else if (wrEn && paddr == `OFF_CHAN_ENPOL) begin
         enPol_r <= (enPol_r & ~enPolMask) | (pwdata[15:0] & enPolMask);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dirSel_r <= `ZERO8;
      end else if (wrEn && paddr == `OFF_DIRECTION) begin
         dirSel_r <= pwdata[7:0];
      end
   end

   // lock field is written once after reset; brake clears main enable
   always_ff @(posedge clk) begin
      if (reset) begin
         brake_r   <= `ZERO16;
         lockSet_r <= 1'b0;
      end else begin
         if (wrEn && paddr == `OFF_BRAKE_CTRL) begin
            brake_r[`BRK_MOE_BIT] <= pwdata[`BRK_MOE_BIT];
            brake_r[7:0] <= pwdata[7:0];
            if (lockLevel == `LOCK_NONE) begin
               brake_r[`BRK_RUN_OFFSTATE_SELECT_BIT] <= pwdata[`BRK_RUN_OFFSTATE_SELECT_BIT];
               brake_r[`BRK_IDLE_OFFSTATE_SELECT_BIT] <= pwdata[`BRK_IDLE_OFFSTATE_SELECT_BIT];
            end
            if (!lockSet_r) begin
               brake_r[`BRK_LOCK_LSB +: 2] <= pwdata[`BRK_LOCK_LSB +: 2];
               lockSet_r <= 1'b1;
            end
         end
         if (brkSync2_r) begin
            brake_r[`BRK_MOE_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reload_r <= `ZERO16;
      end else if (wrEn && paddr == `OFF_RELOAD) begin
         reload_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         repeatLoad_r <= `ZERO8;
      end else if (wrEn && paddr == `OFF_REPEAT) begin
         repeatLoad_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         divLoad_r <= `ZERO16;
      end else if (wrEn && paddr == `OFF_PRESCALE) begin
         divLoad_r <= pwdata[15:0];
      end
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         inSync1_r  <= 4'h0;
         inSync2_r  <= 4'h0;
         inPrev_r   <= 4'h0;
         brkSync1_r <= 1'b0;
         brkSync2_r <= 1'b0;
      end else begin
         inSync1_r  <= chanIn;
         inSync2_r  <= inSync1_r;
         inPrev_r   <= inSync2_r;
         brkSync1_r <= brakeIn;
         brkSync2_r <= brkSync1_r;
      end
   end
   // two-stage sync costs two cycles of brake latency; accepted

   // ****************************************
   // prescaler and counter
   // ****************************************
   // zero reload stops everything
   assign divTick  = (reload_r != `ZERO16) && (divCount_r == divActive_r);
   assign overflow = divTick && (count_r == reload_r);
   // update only when repeat count spent
   assign update   = overflow && (repeatCount_r == `ZERO8);

   always_ff @(posedge clk) begin
      if (reset) begin
         divCount_r  <= `ZERO16;
         divActive_r <= `ZERO16;
      end else begin
         if (reload_r == `ZERO16 || divTick) begin
            divCount_r <= `ZERO16;
         end else begin
            divCount_r <= divCount_r + `ONE16;
         end
         if (update) begin
            divActive_r <= divLoad_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_r <= `ZERO16;
      end else if (wrEn && paddr == `OFF_COUNT) begin
         count_r <= pwdata[15:0];
      end else if (overflow) begin
         count_r <= `ZERO16;
      end else if (divTick) begin
         count_r <= count_r + `ONE16;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         repeatCount_r <= `ZERO8;
      end else if (update) begin
         repeatCount_r <= repeatLoad_r;
      end else if (overflow) begin
         repeatCount_r <= repeatCount_r - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         updateEvent <= 1'b0;
      end else begin
         updateEvent <= update;
      end
   end

   // ****************************************
   // channels
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_chan
         assign isOutput[i] = dirSel_r[2*i +: 2] == `DIR_OUTPUT;
         assign mainEn[i]   = enPol_r[4*i];
         assign mainPol[i]  = enPol_r[4*i+1];
         assign idleLvl[i]  = brake_r[`BRK_IDLE_LSB + 2*i];
         assign cmpActive[i] = count_r < value_r[i];
         assign capEdge[i] = mainPol[i] ? (inPrev_r[i] & ~inSync2_r[i])
                                        : (~inPrev_r[i] & inSync2_r[i]);

         always_ff @(posedge clk) begin
            if (reset) begin
               value_r[i] <= `ZERO16;
            end else if (wrEn && paddr == `OFF_CH1_VALUE + 8'(4*i)) begin
               value_r[i] <= pwdata[15:0];
            end else if (!isOutput[i] && mainEn[i] && capEdge[i]) begin
               value_r[i] <= count_r;
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               chanOut[i]   <= 1'b0;
               chanOutEn[i] <= 1'b1;
            end else if (!isOutput[i]) begin
               chanOut[i]   <= 1'b0;
               chanOutEn[i] <= 1'b1;
            end else if (main_output_enable && mainEn[i]) begin
               chanOut[i]   <= cmpActive[i] ^ mainPol[i];
               chanOutEn[i] <= 1'b0;
            end else if (!main_output_enable && brake_r[`BRK_IDLE_OFFSTATE_SELECT_BIT]) begin
               chanOut[i]   <= idleLvl[i];
               chanOutEn[i] <= 1'b0;
            end else if (main_output_enable && brake_r[`BRK_RUN_OFFSTATE_SELECT_BIT]) begin
               chanOut[i]   <= mainPol[i];
               chanOutEn[i] <= 1'b0;
            end else begin
               chanOut[i]   <= 1'b0;
               chanOutEn[i] <= 1'b1;
            end
         end
      end
      for (i = 0; i < 3; i++) begin : g_comp
         always_ff @(posedge clk) begin
            if (reset) begin
               compOut[i]   <= 1'b0;
               compOutEn[i] <= 1'b1;
            end else if (isOutput[i] && main_output_enable && enPol_r[4*i+2]) begin
               compOut[i]   <= ~cmpActive[i] ^ enPol_r[4*i+3];
               compOutEn[i] <= 1'b0;
            end else if (isOutput[i] && !main_output_enable
                         && brake_r[`BRK_IDLE_OFFSTATE_SELECT_BIT]) begin
               compOut[i]   <= brake_r[`BRK_IDLE_LSB + 2*i + 1];
               compOutEn[i] <= 1'b0;
            end else begin
               compOut[i]   <= 1'b0;
               compOutEn[i] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule

/* shared/timer_defines.svh */
// register offsets, field positions and reset values of the timer block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define OFF_DIRECTION   8'h18
`define OFF_CHAN_ENPOL  8'h20
`define OFF_COUNT       8'h24
`define OFF_PRESCALE    8'h28
`define OFF_RELOAD      8'h2C
`define OFF_REPEAT      8'h30
`define OFF_CH1_VALUE   8'h34
`define OFF_CH2_VALUE   8'h38
`define OFF_CH3_VALUE   8'h3C
`define OFF_CH4_VALUE   8'h40
`define OFF_BRAKE_CTRL  8'h44
`define ENPOL_WMASK     16'h3FFF
`define REPEAT_WMASK    16'h00FF
`define DIRSEL_WMASK    16'h00FF
`define BRK_MOE_BIT     15
`define BRK_RUN_OFFSTATE_SELECT_BIT    11
`define BRK_IDLE_OFFSTATE_SELECT_BIT    10
`define BRK_LOCK_LSB    8
`define BRK_IDLE_LSB    0
`define BRK_WMASK       16'h8FFF
`define LOCK_LEVEL2     2'h2
`define LOCK_NONE       2'h0
`define ENPOL_LOCK_WMASK 16'h1555
`define ZERO32          32'h0000_0000
`define ZERO16          16'h0000
`define ONE16           16'h0001
`define ZERO8           8'h00
`define DIR_OUTPUT      2'h0
`endif

/* shared/timer_pkg.sv */
// types shared by the timer block
package timer_pkg;
   typedef logic [15:0] word16_t;
   typedef logic [1:0]  dirsel_t;
endpackage
